// [dag_pkg.sv]
`default_nettype none
package dag_pkg;
   // Register file geometry
   localparam int unsigned DAG_REG_W = 32;
   localparam int unsigned DAG_HALF_W = 16;
   localparam int unsigned DAG_SLOTS = 8;
   localparam logic [3:0] DAG_R2 = 4'h2;
   localparam logic [3:0] DAG_R4 = 4'h4;
   localparam logic [3:0] DAG_R6 = 4'h6;
   localparam logic [3:0] DAG_R8 = 4'h8;
   localparam logic [3:0] DAG_R9 = 4'h9;
   // Pointer steps in bytes
   localparam logic [15:0] DAG_XY_STEP = 16'h0002;
   localparam logic [31:0] DAG_WORD_STEP = 32'h0000_0002;
   localparam logic [31:0] DAG_LONG_STEP = 32'h0000_0004;
   // Reset value of every pointer and offset
   localparam logic [31:0] DAG_REG_RST = 32'h0000_0000;

   typedef enum logic [1:0] {DAG_KIND_IDLE, DAG_KIND_DUAL, DAG_KIND_SINGLE} dag_kind_t;
   typedef enum logic [1:0] {DAG_UPD_NONE, DAG_UPD_INC, DAG_UPD_INDEX, DAG_UPD_DEC} dag_upd_t;

   // One transfer request from the decoder
   typedef struct packed {
      dag_kind_t kind;
      dag_upd_t x_upd;
      dag_upd_t y_upd;
      logic x_sel;
      logic y_sel;
      logic x_store;
      logic y_store;
      logic x_reg;
      logic y_reg;
      logic [1:0] s_sel;
      dag_upd_t s_upd;
      logic s_long;
      logic s_store;
      logic [3:0] s_reg;
   } dag_req_t;

   // General register write, in or out
   typedef struct packed {
      logic valid;
      logic [3:0] idx;
      logic [31:0] data;
   } dag_gwr_t;

   typedef struct packed {
      logic x_en;
      logic y_en;
      logic [15:0] start;
      logic [15:0] stop;
   } dag_wrap_t;

   typedef struct packed {
      logic req;
      logic store;
      logic reg_sel;
      logic [15:1] addr;
   } dag_xy_bus_t;

   typedef struct packed {
      logic req;
      logic store;
      logic long_len;
      logic [3:0] reg_sel;
      logic [31:0] addr;
   } dag_s_bus_t;
endpackage
`default_nettype wire

// [dag_addr_gen.sv]
// What this block does
// RULE_01: Dual X pointer R4/R5, Y pointer R6/R7
// RULE_02: R8 steps X pointer, R9 steps Y
// RULE_03: Dual increment adds two after access
// RULE_04: Dual index adds offset after; none holds
// RULE_05: X/Y address uses pointer bits 1-15 only
// RULE_06: Software keeps bit 0 of pointers zero
// RULE_07: Software steps down with minus-two offset
// RULE_08: Dual update writes lower word only
// RULE_09: X/Y memories accessed as 16-bit words
// RULE_10: X and Y transfers run together, separately
// RULE_11: Only pointer addressing, no immediate form
// RULE_12: Transfers leave condition bits untouched
// RULE_13: Single pointer chosen from R2 to R5
// RULE_14: Single index mode adds R8 after access
// RULE_15: Single increment adds two or four after
// RULE_16: Single decrement subtracts first, uses result
// RULE_17: Single moves word or long, any memory
// RULE_18: Dual loads X0/X1, Y0/Y1; stores A0/A1
// RULE_19: Wrap only for dual, never single
// RULE_20: Lower word equal end loads start instead
// RULE_21: Both wrap enables set: only Y wraps
// RULE_22: Single step two for word, four long
`timescale 1ns/1ps
`default_nettype none
module dag_addr_gen (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   // Transfer request and wrap setup
   input wire dag_pkg::dag_req_t i_req,
   input wire dag_pkg::dag_wrap_t i_wrap,
   // Core writes to R2..R9
   input wire dag_pkg::dag_gwr_t i_gwr,
   // Memory address buses
   output dag_pkg::dag_xy_bus_t o_x_bus,
   output dag_pkg::dag_xy_bus_t o_y_bus,
   output dag_pkg::dag_s_bus_t o_s_bus,
   // Updated pointers back to the core
   output dag_pkg::dag_gwr_t o_wb_a,
   output dag_pkg::dag_gwr_t o_wb_b
);
   import dag_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Reset release
   logic rst_meta_q;
   logic rst_sync_b;

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rst_meta_q <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_b <= rst_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [2:0] slot_of(input logic [3:0] rn);
      logic [3:0] s;
      s = rn - DAG_R2;
      return s[2:0];
   endfunction

   function automatic logic [15:0] dual_step(input dag_upd_t upd,
                                             input logic [31:0] ofs);
      logic [15:0] st;
      st = 16'h0000;
      if (upd == DAG_UPD_INC) begin
         st = DAG_XY_STEP;
      end else if (upd == DAG_UPD_INDEX) begin
         st = ofs[15:0];
      end
      return st;
   endfunction

   // Dual modes that move a pointer; decrement acts as no update
   function automatic logic dual_moves(input dag_upd_t upd);
      return upd == DAG_UPD_INC || upd == DAG_UPD_INDEX;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pointer and offset storage, slots hold R2..R9
   logic [31:0] regs_q [DAG_SLOTS];
   logic [31:0] regs_d [DAG_SLOTS];

   wire logic is_dual = i_req.kind == DAG_KIND_DUAL;
   wire logic is_single = i_req.kind == DAG_KIND_SINGLE;

   // RULE_01: dual pointer pick
   wire logic [3:0] x_rn = DAG_R4 + {3'h0, i_req.x_sel};
   wire logic [3:0] y_rn = DAG_R6 + {3'h0, i_req.y_sel};
   // RULE_13: single pointer pick
   wire logic [3:0] s_rn = DAG_R2 + {2'h0, i_req.s_sel};
   wire logic [2:0] x_slot = slot_of(x_rn);
   wire logic [2:0] y_slot = slot_of(y_rn);
   wire logic [2:0] s_slot = slot_of(s_rn);
   wire logic [31:0] x_cur = regs_q[x_slot];
   wire logic [31:0] y_cur = regs_q[y_slot];
   wire logic [31:0] s_cur = regs_q[s_slot];
   // RULE_02: offset registers
   wire logic [31:0] x_ofs = regs_q[slot_of(DAG_R8)];
   wire logic [31:0] y_ofs = regs_q[slot_of(DAG_R9)];

   ////////////////////////////////////////////////////////////////////////
   // Dual X/Y update
   // RULE_21: Y owns wrap when both set
   wire logic x_wrap_on = i_wrap.x_en && !i_wrap.y_en;
   wire logic y_wrap_on = i_wrap.y_en;
   // RULE_03: step is post access
   wire logic [15:0] x_step = dual_step(i_req.x_upd, x_ofs);
   wire logic [15:0] y_step = dual_step(i_req.y_upd, y_ofs);
   // RULE_20: end match reloads start
   wire logic x_hit = x_wrap_on && dual_moves(i_req.x_upd)
                      && x_cur[15:0] == i_wrap.stop;
   wire logic y_hit = y_wrap_on && dual_moves(i_req.y_upd)
                      && y_cur[15:0] == i_wrap.stop;
   wire logic [15:0] x_low = x_hit ? i_wrap.start : x_cur[15:0] + x_step;
   wire logic [15:0] y_low = y_hit ? i_wrap.start : y_cur[15:0] + y_step;
   // RULE_08: upper word kept
   wire logic [31:0] x_new = {x_cur[31:16], x_low};
   wire logic [31:0] y_new = {y_cur[31:16], y_low};

   ////////////////////////////////////////////////////////////////////////
   // Single update, never wrapped
   // RULE_22: word two, long four
   wire logic [31:0] s_size = i_req.s_long ? DAG_LONG_STEP : DAG_WORD_STEP;
   // RULE_19: single step ignores wrap
   wire logic [31:0] s_step = (i_req.s_upd == DAG_UPD_INC) ? s_size :
                              (i_req.s_upd == DAG_UPD_INDEX) ? x_ofs :
                              (i_req.s_upd == DAG_UPD_DEC) ? (32'h0 - s_size) :
                              32'h0;
   // RULE_14: post index add
   // RULE_15: increment applied after access
   wire logic [31:0] s_new = s_cur + s_step;
   // RULE_16: decrement addresses the new value
   wire logic [31:0] s_addr = (i_req.s_upd == DAG_UPD_DEC) ? s_new : s_cur;

   // RULE_04: no update leaves pointer alone
   wire logic x_wr = is_dual && dual_moves(i_req.x_upd);
   wire logic y_wr = is_dual && dual_moves(i_req.y_upd);
   wire logic s_wr = is_single && i_req.s_upd != DAG_UPD_NONE;
   wire logic [2:0] gwr_slot = slot_of(i_gwr.idx);
   wire logic gwr_ok = i_gwr.valid && i_gwr.idx >= DAG_R2 && i_gwr.idx <= DAG_R9;

   // Transfer update wins over a core write to the same slot
   for (genvar g = 0; g < DAG_SLOTS; g++) begin : g_slot
      always_comb begin
         regs_d[g] = regs_q[g];
         if (x_wr && x_slot == 3'(g)) begin
            regs_d[g] = x_new;
         end else if (y_wr && y_slot == 3'(g)) begin
            regs_d[g] = y_new;
         end else if (s_wr && s_slot == 3'(g)) begin
            regs_d[g] = s_new;
         end else if (gwr_ok && gwr_slot == 3'(g)) begin
            regs_d[g] = i_gwr.data;
         end
      end

      always_ff @(posedge i_sys_clk or negedge rst_sync_b) begin
         if (!rst_sync_b) begin
            regs_q[g] <= DAG_REG_RST;
         end else begin
            regs_q[g] <= regs_d[g];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus outputs
   dag_xy_bus_t x_bus_d;
   dag_xy_bus_t y_bus_d;
   dag_s_bus_t s_bus_d;
   dag_gwr_t wb_a_d;
   dag_gwr_t wb_b_d;

   always_comb begin
      // RULE_10: X and Y issued in one cycle
      // RULE_05: bits 15..1 form the word address
      // RULE_09: word-only buses carry no size
      // RULE_11: address comes from a pointer only
      // RULE_18: X0/X1, Y0/Y1 or A0/A1 select
      x_bus_d = '{req: is_dual, store: i_req.x_store, reg_sel: i_req.x_reg,
                  addr: x_cur[15:1]};
      y_bus_d = '{req: is_dual, store: i_req.y_store, reg_sel: i_req.y_reg,
                  addr: y_cur[15:1]};
      // RULE_17: word or long to any space
      s_bus_d = '{req: is_single, store: i_req.s_store, long_len: i_req.s_long,
                  reg_sel: i_req.s_reg, addr: s_addr};
      wb_a_d = '{valid: x_wr || s_wr, idx: is_dual ? x_rn : s_rn,
                 data: is_dual ? x_new : s_new};
      wb_b_d = '{valid: y_wr, idx: y_rn, data: y_new};
   end

   // RULE_12: no condition bit is driven here
   always_ff @(posedge i_sys_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         o_x_bus <= '0;
         o_y_bus <= '0;
         o_s_bus <= '0;
         o_wb_a <= '0;
         o_wb_b <= '0;
      end else begin
         o_x_bus <= x_bus_d;
         o_y_bus <= y_bus_d;
         o_s_bus <= s_bus_d;
         o_wb_a <= wb_a_d;
         o_wb_b <= wb_b_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_dual;
      i_req.kind == DAG_KIND_DUAL;
   endsequence

   sequence s_single;
      i_req.kind == DAG_KIND_SINGLE;
   endsequence

   a_dual_addr: assert property (  // RULE_05
      @(posedge i_sys_clk) disable iff (!rst_sync_b)
      s_dual |=> o_x_bus.req && o_y_bus.req && o_s_bus.req == 1'b0
         && o_x_bus.addr == $past(x_cur[15:1]) && o_y_bus.addr == $past(y_cur[15:1]))
      else $error("dual addresses wrong");

   a_dual_inc: assert property (  // RULE_03
      @(posedge i_sys_clk) disable iff (!rst_sync_b)
      s_dual ##0 (i_req.x_upd == DAG_UPD_INC && !x_wrap_on)
      |=> regs_q[$past(x_slot)][15:0] == $past(x_cur[15:0]) + 16'h0002)
      else $error("x increment wrong");

   a_upper_kept: assert property (  // RULE_08
      @(posedge i_sys_clk) disable iff (!rst_sync_b)
      s_dual ##0 (i_req.y_upd == DAG_UPD_INDEX)
      |=> regs_q[$past(y_slot)] == {$past(y_cur[31:16]), $past(y_low)}
         && o_wb_b.valid)
      else $error("y upper word changed");

   a_dual_hold: assert property (  // RULE_04
      @(posedge i_sys_clk) disable iff (!rst_sync_b)
      s_dual ##0 (i_req.x_upd == DAG_UPD_NONE && !(gwr_ok && gwr_slot == x_slot))
      |=> regs_q[$past(x_slot)] == $past(x_cur))
      else $error("x pointer moved on no update");

   a_wrap_y_only: assert property (  // RULE_21
      @(posedge i_sys_clk) disable iff (!rst_sync_b)
      s_dual ##0 (i_wrap.x_en && i_wrap.y_en && i_req.x_upd == DAG_UPD_INC)
      |=> regs_q[$past(x_slot)][15:0] == $past(x_cur[15:0]) + 16'h0002)
      else $error("x wrapped while y wrap set");

   a_wrap_load: assert property (  // RULE_20
      @(posedge i_sys_clk) disable iff (!rst_sync_b)
      s_dual ##0 (i_wrap.y_en && dual_moves(i_req.y_upd)
         && y_cur[15:0] == i_wrap.stop)
      |=> regs_q[$past(y_slot)][15:0] == $past(i_wrap.start))
      else $error("y wrap not taken");

   a_single_dec: assert property (  // RULE_16
      @(posedge i_sys_clk) disable iff (!rst_sync_b)
      s_single ##0 (i_req.s_upd == DAG_UPD_DEC)
      |=> o_s_bus.req && o_s_bus.addr == $past(s_cur) - (o_s_bus.long_len ? 32'h4 : 32'h2)
         && regs_q[$past(s_slot)] == o_s_bus.addr)
      else $error("pre-decrement wrong");

   a_single_inc: assert property (  // RULE_15
      @(posedge i_sys_clk) disable iff (!rst_sync_b)
      s_single ##0 (i_req.s_upd == DAG_UPD_INC)
      |=> o_s_bus.addr == $past(s_cur)
         && regs_q[$past(s_slot)] == $past(s_cur) + (o_s_bus.long_len ? 32'h4 : 32'h2))
      else $error("post-increment wrong");

   a_single_nowrap: assert property (  // RULE_19
      @(posedge i_sys_clk) disable iff (!rst_sync_b)
      s_single ##0 (i_req.s_upd == DAG_UPD_INDEX && (i_wrap.x_en || i_wrap.y_en))
      |=> regs_q[$past(s_slot)] == $past(s_cur) + $past(x_ofs))
      else $error("single transfer wrapped");

   a_dual_dec_hold: assert property (  // RULE_04
      @(posedge i_sys_clk) disable iff (!rst_sync_b)
      s_dual ##0 (i_req.x_upd == DAG_UPD_DEC || i_req.y_upd == DAG_UPD_DEC)
      |=> !(o_wb_a.valid && $past(i_req.x_upd) == DAG_UPD_DEC)
         && !(o_wb_b.valid && $past(i_req.y_upd) == DAG_UPD_DEC))
      else $error("dual decrement moved a pointer");

   a_dual_pick: assert property (  // RULE_01
      @(posedge i_sys_clk) disable iff (!rst_sync_b)
      s_dual ##0 (i_req.x_upd == DAG_UPD_INC && i_req.y_upd == DAG_UPD_INC)
      |=> o_wb_a.valid && o_wb_a.idx == (DAG_R4 | 4'($past(i_req.x_sel)))
         && o_wb_b.valid && o_wb_b.idx == (DAG_R6 | 4'($past(i_req.y_sel))))
      else $error("dual pointer register wrong");

   a_single_pick: assert property (  // RULE_13
      @(posedge i_sys_clk) disable iff (!rst_sync_b)
      s_single ##0 (i_req.s_upd != DAG_UPD_NONE)
      |=> o_wb_a.valid && !o_wb_b.valid
         && o_wb_a.idx == DAG_R2 + 4'($past(i_req.s_sel)))
      else $error("single pointer register wrong");

   a_single_index: assert property (  // RULE_14
      @(posedge i_sys_clk) disable iff (!rst_sync_b)
      s_single ##0 (i_req.s_upd == DAG_UPD_INDEX)
      |=> o_s_bus.addr == $past(s_cur) && o_wb_a.data == $past(s_cur) + $past(x_ofs))
      else $error("single index add wrong");
endmodule // dag_addr_gen
`default_nettype wire

// [dag_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dag_mem_model (
   // Clock
   input wire logic i_sys_clk,
   // Address buses from the generator
   input wire dag_pkg::dag_xy_bus_t i_x_bus,
   input wire dag_pkg::dag_xy_bus_t i_y_bus,
   input wire dag_pkg::dag_s_bus_t i_s_bus
);
   import dag_pkg::*;
   int n_pair = 0;
   int n_s = 0;
   logic [15:0] x_mem [0:255];
   logic [15:0] y_mem [0:255];
   always @(posedge i_sys_clk) begin
      if (i_x_bus.req && i_y_bus.req) begin
         n_pair++;
         if (i_x_bus.store) x_mem[i_x_bus.addr[8:1]] <= 16'h0000;
         if (i_y_bus.store) y_mem[i_y_bus.addr[8:1]] <= 16'h0000;
      end
      if (i_s_bus.req) n_s++;
   end
endmodule // dag_mem_model
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import dag_pkg::*;
   logic i_sys_clk = 1'b0;
   logic i_rst_b = 1'b0;
   dag_req_t i_req = '0;
   dag_wrap_t i_wrap = '0;
   dag_wrap_t wrap_n = '0;
   dag_gwr_t i_gwr = '0;
   dag_xy_bus_t o_x_bus, o_y_bus;
   dag_xy_bus_t e_x = '0;
   dag_xy_bus_t e_y = '0;
   dag_s_bus_t o_s_bus;
   dag_s_bus_t e_s = '0;
   dag_gwr_t o_wb_a, o_wb_b;
   dag_gwr_t e_a = '0;
   dag_gwr_t e_b = '0;
   int err_count = 0;
   int compares = 0;
   int n_dual = 0;
   int n_single = 0;
   logic [31:0] seed = 32'h9446;
   logic [31:0] rf [2:9];
   logic [31:0] v;
   always #2 i_sys_clk = ~i_sys_clk;
   dag_addr_gen u_dut (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_req(i_req), .i_wrap(i_wrap),
      .i_gwr(i_gwr), .o_x_bus(o_x_bus), .o_y_bus(o_y_bus), .o_s_bus(o_s_bus),
      .o_wb_a(o_wb_a), .o_wb_b(o_wb_b));
   dag_mem_model u_mem (.i_sys_clk(i_sys_clk), .i_x_bus(o_x_bus), .i_y_bus(o_y_bus),
      .i_s_bus(o_s_bus));
   ////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [15:0] low_next(logic [31:0] p, dag_upd_t u, logic [31:0] o, logic w);
      if (w && p[15:0] == wrap_n.stop) return wrap_n.start;
      return p[15:0] + ((u == DAG_UPD_INC) ? DAG_XY_STEP : o[15:0]);
   endfunction
   function automatic dag_req_t mk(dag_kind_t k, logic [1:0] sel, dag_upd_t xu, dag_upd_t yu,
         logic lng);
      dag_req_t r;
      logic [31:0] b;
      b = rnd();
      r = '0;
      r.kind = k;
      {r.x_store, r.y_store, r.x_reg, r.y_reg, r.s_store, r.s_reg} = b[8:0];
      {r.y_sel, r.x_sel} = sel;
      r.s_sel = sel;
      r.x_upd = xu;
      r.y_upd = yu;
      r.s_upd = xu;
      r.s_long = lng;
      return r;
   endfunction
   ////////////////////////////////////////////////////////////////
   task automatic chk_flag(input string n, input logic e, input logic g);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic chk_bus(input string n, input logic [63:0] e, input logic [63:0] g);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic check_out();
      chk_flag("x req", e_x.req, o_x_bus.req);
      if (e_x.req) chk_bus("x bus", 64'(e_x), 64'(o_x_bus));
      chk_flag("y req", e_y.req, o_y_bus.req);
      if (e_y.req) chk_bus("y bus", 64'(e_y), 64'(o_y_bus));
      chk_flag("s req", e_s.req, o_s_bus.req);
      if (e_s.req) chk_bus("s bus", 64'(e_s), 64'(o_s_bus));
      chk_flag("wb a valid", e_a.valid, o_wb_a.valid);
      if (e_a.valid) chk_bus("wb a", 64'(e_a), 64'(o_wb_a));
      chk_flag("wb b valid", e_b.valid, o_wb_b.valid);
      if (e_b.valid) chk_bus("wb b", 64'(e_b), 64'(o_wb_b));
   endtask
   task automatic predict(input dag_req_t r, input dag_gwr_t g);
      logic [3:0] xi, yi, si;
      logic [31:0] st, nv;
      e_x = '0;
      e_y = '0;
      e_s = '0;
      e_a = '0;
      e_b = '0;
      xi = DAG_R4 + 4'(r.x_sel);
      yi = DAG_R6 + 4'(r.y_sel);
      si = DAG_R2 + 4'(r.s_sel);
      if (r.kind == DAG_KIND_DUAL) begin
         n_dual++;
         e_x = '{1'b1, r.x_store, r.x_reg, rf[xi][15:1]};
         e_y = '{1'b1, r.y_store, r.y_reg, rf[yi][15:1]};
         if (r.x_upd inside {DAG_UPD_INC, DAG_UPD_INDEX}) begin
            e_a = '{1'b1, xi, {rf[xi][31:16],
               low_next(rf[xi], r.x_upd, rf[8], wrap_n.x_en && !wrap_n.y_en)}};
         end
         if (r.y_upd inside {DAG_UPD_INC, DAG_UPD_INDEX}) begin
            e_b = '{1'b1, yi, {rf[yi][31:16], low_next(rf[yi], r.y_upd, rf[9], wrap_n.y_en)}};
         end
      end else if (r.kind == DAG_KIND_SINGLE) begin
         n_single++;
         st = r.s_long ? DAG_LONG_STEP : DAG_WORD_STEP;
         nv = (r.s_upd == DAG_UPD_INC) ? rf[si] + st :
            (r.s_upd == DAG_UPD_DEC) ? rf[si] - st : rf[si] + rf[8];
         e_s = '{1'b1, r.s_store, r.s_long, r.s_reg, (r.s_upd == DAG_UPD_DEC) ? nv : rf[si]};
         if (r.s_upd != DAG_UPD_NONE) e_a = '{1'b1, si, nv};
      end
      if (g.valid && g.idx >= DAG_R2 && g.idx <= DAG_R9) rf[g.idx] = g.data;
      if (e_a.valid) rf[e_a.idx] = e_a.data;
      if (e_b.valid) rf[e_b.idx] = e_b.data;
   endtask
   task automatic send(input dag_req_t r, input dag_gwr_t g);
      @(posedge i_sys_clk);
      i_req <= r;
      i_gwr <= g;
      i_wrap <= wrap_n;
      #1;
      check_out();
      predict(r, g);
   endtask
   task automatic wr(input logic [3:0] idx, input logic [31:0] d);
      send('0, '{1'b1, idx, d});
   endtask
   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (6000) @(posedge i_sys_clk);
      err_count++;
      conclude();
   end
   initial begin
      for (int i = 2; i <= 9; i++) rf[i] = DAG_REG_RST;
      repeat (4) @(posedge i_sys_clk);
      i_rst_b <= 1'b1;
      repeat (2) @(posedge i_sys_clk);
      // Wrap at end value, upper word kept
      wr(4'h4, 32'h1234_c008);
      wrap_n = '{1'b1, 1'b0, 16'hc008, 16'hc00c};
      repeat (4) send(mk(DAG_KIND_DUAL, 2'b00, DAG_UPD_INC, DAG_UPD_NONE, 1'b0), '0);
      $display("test wrap done");
      wrap_n.y_en = 1'b1;
      wr(4'h4, 32'h0000_c00c);
      wr(4'h6, 32'h0000_c00c);
      send(mk(DAG_KIND_DUAL, 2'b00, DAG_UPD_INC, DAG_UPD_INC, 1'b0), '0);
      $display("test both wraps done");
      wrap_n = '0;
      // Minus two offset steps down
      wr(4'h8, 32'hffff_fffe);
      wr(4'h5, 32'h0001_0000);
      wr(4'h9, 32'h0000_0004);
      wr(4'h7, 32'h5555_fffc);
      send(mk(DAG_KIND_DUAL, 2'b11, DAG_UPD_INDEX, DAG_UPD_INDEX, 1'b0), '0);
      send(mk(DAG_KIND_DUAL, 2'b11, DAG_UPD_DEC, DAG_UPD_NONE, 1'b0), '0);
      $display("test index done");
      wrap_n = '{1'b1, 1'b0, 16'h0100, 16'h0000};
      for (int i = 2; i <= 5; i++) begin
         wr(4'(i), rnd() & ((i >= 4) ? 32'hffff_fffe : 32'hffff_ffff));
      end
      for (int m = 0; m < 32; m++) begin
         send(mk(DAG_KIND_SINGLE, 2'(m), dag_upd_t'(m[3:2]), DAG_UPD_NONE, m[4]), '0);
      end
      $display("test single modes done");
      for (int n = 0; n < 400; n++) begin
         v = rnd();
         // bit 0 of dual registers kept clear
         send((v[1:0] == 2'b00) ? dag_req_t'('0) :
            mk(v[1] ? DAG_KIND_DUAL : DAG_KIND_SINGLE, v[3:2], dag_upd_t'(v[5:4]),
            dag_upd_t'(v[7:6]), v[8]),
            '{v[9], v[13:10], rnd() & ((v[13:10] >= 4'h4) ? 32'hffff_fffe : 32'hffff_ffff)});
      end
      $display("test random done");
      repeat (3) send('0, '0);
      chk_bus("pair count", 64'(n_dual), 64'(u_mem.n_pair));
      chk_bus("single count", 64'(n_single), 64'(u_mem.n_s));
      conclude();
   end
endmodule // testbench
`default_nettype wire
